// ---- logic/cpfi_params.svh ----
// constants for the card presence and fault interrupt block
// assumes a 50 MHz core clock
`ifndef CPFI_PARAMS_SVH
`define CPFI_PARAMS_SVH
`define CPFI_CLK_MHZ          50
`define CPFI_DEBOUNCE_MS      8
`define CPFI_DEBOUNCE_CYCLES  (`CPFI_DEBOUNCE_MS * 1000 * `CPFI_CLK_MHZ)
`define CPFI_CLK_DELAY_US     12
`define CPFI_CLK_DELAY_CYCLES (`CPFI_CLK_DELAY_US * `CPFI_CLK_MHZ)
`define CPFI_STEP_CYCLES      1
`endif

// ---- logic/cpfi_pkg.sv ----
// types for the card presence and fault interrupt block
// assumes nothing of its surroundings
package cpfi_pkg;
	typedef enum logic [2:0] {
		CPFI_IDLE   = 3'h0,
		CPFI_ACTIVE = 3'h1,
		CPFI_RST_LO = 3'h3,
		CPFI_CLK_LO = 3'h2,
		CPFI_IO_LO  = 3'h6,
		CPFI_PWR_LO = 3'h7
	} cpfi_state_t;
endpackage : cpfi_pkg

// ---- logic/cpfi_sync.sv ----
// two-flop synchroniser for pin inputs
// assumes asynchronous inputs and a shared clock enable
`timescale 1ns/10ps
`default_nettype none
module cpfi_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	// data
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// next values
	always_comb begin
		meta_d = ce_in ? d_in : meta_q;
		sync_d = ce_in ? meta_q : sync_q;
	end

	// flops; first stage feeds only the second
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_out = sync_q;
endmodule : cpfi_sync
`default_nettype wire

// ---- logic/cpfi_top.sv ----
// card presence and fault interrupt with deactivation sequencer
// assumes pins from outside the clock domain; one 50 MHz clock
// Overview of operation
// - session opens on falling edge of session_request_n
// - outside session, interrupt low when no card, either switch polarity
// - outside session, interrupt high when card present and supply valid
// - supply lockout with card present drops interrupt at once
// - interrupt returns high only after supply recovers and card still present
// - during session any fault drops the interrupt
// - fault in session starts deactivation on its own
// - insertion runs 8 ms debounce; interrupt high only on expiry
// - removal starts deactivation and drops interrupt with no delay
// - deactivate: reset low, clock and io/aux low together 12 us later, supply off
// - faults: extraction, supply lockout, card supply overload, overheating
`timescale 1ns/10ps
`default_nettype none
`include "cpfi_params.svh"
module cpfi_top
	import cpfi_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES  = `CPFI_DEBOUNCE_CYCLES,
	parameter int CLK_DELAY_CYCLES = `CPFI_CLK_DELAY_CYCLES
) (
	// clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	// host side
	input  wire logic session_request_n_in,
	output logic      int_n_out,
	// card presence and fault pins
	input  wire logic card_presence_input_in,
	input  wire logic presence_active_high_in,
	input  wire logic supply_low_lockout_in,
	input  wire logic card_supply_fault_in,
	input  wire logic overheat_in,
	// card side enables (high = line active)
	output logic      card_reset_line_en_out,
	output logic      card_clock_line_en_out,
	output logic      card_io_line_en_out,
	output logic      card_aux_line_one_en_out,
	output logic      card_aux_line_two_en_out,
	output logic      card_supply_output_en_out,
	output logic      deact_busy_out
);
	// refuse counts that the counters cannot serve
	if (DEBOUNCE_CYCLES < 1 || CLK_DELAY_CYCLES < 1) begin : g_bad_counts
		$error("cpfi_top: counts must be at least one");
	end

	localparam int CW = $clog2(DEBOUNCE_CYCLES + 1) > $clog2(CLK_DELAY_CYCLES + 1) ?
		$clog2(DEBOUNCE_CYCLES + 1) : $clog2(CLK_DELAY_CYCLES + 1);
	localparam logic [CW-1:0] DEB_LAST = CW'(DEBOUNCE_CYCLES - 1);
	localparam logic [CW-1:0] CLK_LAST = CW'(CLK_DELAY_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [5:0] pins_s;
	cpfi_sync #(.WIDTH(6)) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.ce_in  (ce_in),
		.d_in   ({~session_request_n_in, card_presence_input_in, presence_active_high_in,
		          supply_low_lockout_in, card_supply_fault_in, overheat_in}),
		.q_out  (pins_s)
	);
	logic req_s, card_presence_input_raw_s, pol_s, supply_low_lockout_s, csf_s, ot_s;
	assign {req_s, card_presence_input_raw_s, pol_s, supply_low_lockout_s, csf_s, ot_s} = pins_s;

	// request travels inverted so the synchroniser reset reads as idle, no false edge
	logic req_n_s;
	assign req_n_s = ~req_s;

	// presence in either switch polarity
	logic card_presence_input_s;
	assign card_presence_input_s = pol_s ? card_presence_input_raw_s : ~card_presence_input_raw_s;

	////////////////////////////////////////////////////////////////////////////
	// request edge, debounce and presence state
	logic          req_prev_q, req_prev_d;
	logic          card_presence_input_ok_q, card_presence_input_ok_d;
	logic [CW-1:0] deb_cnt_q, deb_cnt_d;
	logic          open_cmd;
	logic          fault;

	assign open_cmd = req_prev_q & ~req_n_s;
	assign fault    = ~card_presence_input_s | supply_low_lockout_s | csf_s | ot_s;

	// debounce next values
	always_comb begin
		req_prev_d = req_prev_q;
		card_presence_input_ok_d  = card_presence_input_ok_q;
		deb_cnt_d  = deb_cnt_q;
		if (ce_in) begin
			req_prev_d = req_n_s;
			if (!card_presence_input_s) begin
				card_presence_input_ok_d = 1'b0;
				deb_cnt_d = '0;
			end else if (!card_presence_input_ok_q) begin
				if (deb_cnt_q == DEB_LAST) begin
					card_presence_input_ok_d = 1'b1;
					deb_cnt_d = '0;
				end else begin
					deb_cnt_d = deb_cnt_q + CW'(1);
				end
			end
		end
	end

	// debounce flops
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			req_prev_q <= 1'b1;
			card_presence_input_ok_q  <= 1'b0;
			deb_cnt_q  <= '0;
		end else begin
			req_prev_q <= req_prev_d;
			card_presence_input_ok_q  <= card_presence_input_ok_d;
			deb_cnt_q  <= deb_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// session and deactivation sequencer
	cpfi_state_t   st_q, st_d;
	logic [CW-1:0] seq_cnt_q, seq_cnt_d;
	logic          flt_q, flt_d;

	// sequencer next values
	always_comb begin
		st_d      = st_q;
		seq_cnt_d = seq_cnt_q;
		flt_d     = flt_q;
		if (ce_in) begin
			unique case (st_q)
				CPFI_IDLE: begin
					flt_d = 1'b0;
					if (open_cmd && card_presence_input_ok_q && !fault) begin
						st_d = CPFI_ACTIVE;
					end
				end
				CPFI_ACTIVE: begin
					if (fault) begin
						st_d  = CPFI_RST_LO;
						flt_d = 1'b1;
					end else if (req_n_s) begin
						st_d = CPFI_RST_LO;
					end
				end
				CPFI_RST_LO: begin
					seq_cnt_d = '0;
					st_d      = CPFI_CLK_LO;
				end
				CPFI_CLK_LO: begin
					if (seq_cnt_q == CLK_LAST) begin
						st_d = CPFI_IO_LO;
					end else begin
						seq_cnt_d = seq_cnt_q + CW'(1);
					end
				end
				CPFI_IO_LO: st_d = CPFI_PWR_LO;
				CPFI_PWR_LO: begin
					if (req_n_s) begin
						st_d = CPFI_IDLE;
					end
				end
				default: st_d = CPFI_IDLE;
			endcase
		end
	end

	// sequencer flops
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q      <= CPFI_IDLE;
			seq_cnt_q <= '0;
			flt_q     <= 1'b0;
		end else begin
			st_q      <= st_d;
			seq_cnt_q <= seq_cnt_d;
			flt_q     <= flt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	logic int_n_q, int_n_d;
	logic act_q, act_d;
	logic rst_en_q, rst_en_d, clk_en_q, clk_en_d, io_en_q, io_en_d;

	// output next values
	always_comb begin
		int_n_d  = int_n_q;
		act_d    = act_q;
		rst_en_d = rst_en_q;
		clk_en_d = clk_en_q;
		io_en_d  = io_en_q;
		if (ce_in) begin
			// session fault latched until idle; else presence and supply
			int_n_d  = card_presence_input_ok_q & card_presence_input_s & ~supply_low_lockout_s & ~flt_d;
			act_d    = (st_d != CPFI_IDLE) && (st_d != CPFI_PWR_LO);
			rst_en_d = (st_d == CPFI_ACTIVE);
			clk_en_d = (st_d == CPFI_ACTIVE) || (st_d == CPFI_RST_LO) ||
			           (st_d == CPFI_CLK_LO);
			io_en_d  = clk_en_d;
		end
	end

	// output flops
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_n_q  <= 1'b0;
			act_q    <= 1'b0;
			rst_en_q <= 1'b0;
			clk_en_q <= 1'b0;
			io_en_q  <= 1'b0;
		end else begin
			int_n_q  <= int_n_d;
			act_q    <= act_d;
			rst_en_q <= rst_en_d;
			clk_en_q <= clk_en_d;
			io_en_q  <= io_en_d;
		end
	end

	assign int_n_out                 = int_n_q;
	assign card_reset_line_en_out    = rst_en_q;
	assign card_clock_line_en_out    = clk_en_q;
	assign card_io_line_en_out       = io_en_q;
	assign card_aux_line_one_en_out  = io_en_q;
	assign card_aux_line_two_en_out  = io_en_q;
	assign card_supply_output_en_out = act_q;
	assign deact_busy_out            = (st_q != CPFI_IDLE) && (st_q != CPFI_ACTIVE);
endmodule : cpfi_top
`default_nettype wire

// ---- test/cpfi_properties.sv ----
// checker on the ports of cpfi_top
// assumes ce_in held high and the test counts passed in
`timescale 1ns/10ps
`default_nettype none
module cpfi_properties #(
	parameter int DEBOUNCE_CYCLES  = 20,
	parameter int CLK_DELAY_CYCLES = 5
) (
	// clock and reset
	input wire logic clk_in, rst_in, ce_in,
	// host and pins
	input wire logic session_request_n_in, int_n_out, card_presence_input_in, presence_active_high_in,
	input wire logic supply_low_lockout_in, card_supply_fault_in, overheat_in,
	// card side
	input wire logic card_reset_line_en_out, card_clock_line_en_out, card_io_line_en_out,
	input wire logic card_aux_line_one_en_out, card_aux_line_two_en_out, card_supply_output_en_out, deact_busy_out
);
	logic card_presence_input, flt;
	int   stab_q, stab_d, gap_q, gap_d;
	assign card_presence_input = card_presence_input_in == presence_active_high_in;
	assign flt  = card_supply_fault_in | overheat_in;
	// presence stable time and reset-to-clock gap
	always_comb begin
		stab_d = card_presence_input ? stab_q + 1 : 0;
		gap_d  = card_reset_line_en_out ? 0 : gap_q + int'(card_clock_line_en_out);
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stab_q <= 0;
			gap_q  <= 0;
		end else begin
			stab_q <= stab_d;
			gap_q  <= gap_d;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_supply_low_lockout; $rose(supply_low_lockout_in) |-> ##[1:5] !int_n_out; endproperty
	a_supply_low_lockout: assert property (p_supply_low_lockout) else $error("int high after lockout");
	property p_rise;
		$rose(int_n_out) |-> stab_q >= DEBOUNCE_CYCLES && !supply_low_lockout_in && session_request_n_in;
	endproperty
	a_rise: assert property (p_rise) else $error("int rose early");
	property p_flt; $rose(flt) && !session_request_n_in |-> ##[1:5] !int_n_out && !card_reset_line_en_out; endproperty
	a_flt: assert property (p_flt) else $error("fault not acted on");
	property p_rem; $fell(card_presence_input) |-> ##[1:5] !int_n_out && !card_reset_line_en_out; endproperty
	a_rem: assert property (p_rem) else $error("removal not acted on");
	property p_open;
		$fell(session_request_n_in) && int_n_out && !deact_busy_out && !flt |-> ##[1:5] card_supply_output_en_out;
	endproperty
	a_open: assert property (p_open) else $error("session not opened");
	property p_clk; $fell(card_clock_line_en_out) |-> gap_q inside {[CLK_DELAY_CYCLES:CLK_DELAY_CYCLES+1]}; endproperty
	a_clk: assert property (p_clk) else $error("clock drop gap wrong");
	property p_sup;
		$fell(card_supply_output_en_out) |-> !(card_clock_line_en_out | card_io_line_en_out
			| card_aux_line_one_en_out | card_aux_line_two_en_out);
	endproperty
	a_sup: assert property (p_sup) else $error("supply off too soon");
	property p_busy; $fell(card_reset_line_en_out) |-> deact_busy_out; endproperty
	a_busy: assert property (p_busy) else $error("no busy in teardown");
	c_open: cover property ($rose(card_supply_output_en_out));
	c_rise: cover property ($rose(int_n_out));
	c_off: cover property ($fell(card_supply_output_en_out));
endmodule : cpfi_properties
bind cpfi_top cpfi_properties #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .CLK_DELAY_CYCLES(CLK_DELAY_CYCLES)) i_props (.*);
`default_nettype wire

// ---- test/cpfi_host_model.sv ----
// host model: drives session request, reads interrupt
// assumes tasks are called after reset, at a falling edge
`timescale 1ns/10ps
`default_nettype none
module cpfi_host_model #(
	parameter int WAIT_CYCLES = 40
) (
	input  wire logic clk_in,
	input  wire logic int_n_in,
	output var logic  session_request_n_out
);
	initial session_request_n_out = 1'h1;
	// open: request high a while, then falls
	task automatic open_session();
		repeat (4) @(negedge clk_in);
		session_request_n_out = 1'h0;
		repeat (6) @(negedge clk_in);
	endtask : open_session
	// close: release, wait out teardown, then read
	task automatic close_session(output logic int_n);
		session_request_n_out = 1'h1;
		repeat (WAIT_CYCLES) @(negedge clk_in);
		int_n = int_n_in;
	endtask : close_session
endmodule : cpfi_host_model
`default_nettype wire

// ---- test/cpfi_testbench.sv ----
// self-checking bench for cpfi_top
// assumes short debounce and clock delay counts
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int DEB = 20;
	localparam int DLY = 5;
	logic clk_in = 1'h0, rst_in = 1'h1, card_presence_input = 1'h0, pol = 1'h1, supply_low_lockout = 1'h0, ovl = 1'h0, hot = 1'h0;
	logic req_n, int_n, rst_en, clk_en, sup_en, v, io_en, aux1_en, aux2_en, busy;
	int   err_count = 0, checked = 0;
	always #10 clk_in = ~clk_in;
	cpfi_top #(.DEBOUNCE_CYCLES(DEB), .CLK_DELAY_CYCLES(DLY)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
		.ce_in(1'h1), .session_request_n_in(req_n), .int_n_out(int_n), .card_presence_input_in(card_presence_input),
		.presence_active_high_in(pol), .supply_low_lockout_in(supply_low_lockout), .card_supply_fault_in(ovl),
		.overheat_in(hot), .card_reset_line_en_out(rst_en), .card_clock_line_en_out(clk_en),
		.card_io_line_en_out(io_en), .card_aux_line_one_en_out(aux1_en), .card_aux_line_two_en_out(aux2_en),
		.card_supply_output_en_out(sup_en), .deact_busy_out(busy));
	cpfi_host_model #(.WAIT_CYCLES(DEB+DLY+12)) i_host (.clk_in(clk_in), .int_n_in(int_n),
		.session_request_n_out(req_n));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	// insertion with a bounce, either switch polarity
	task automatic t_insert(input logic p);
		pol = p;
		card_presence_input = ~p;
		cyc(8);
		chk("int_absent", 1'h0, int_n);
		card_presence_input = p;
		cyc(DEB/2);
		card_presence_input = ~p;
		cyc(2);
		card_presence_input = p;
		cyc(DEB-2);
		chk("int_bounce", 1'h0, int_n);
		cyc(10);
		chk("int_present", 1'h1, int_n);
		$display("insert test done");
	endtask : t_insert
	// supply lockout outside a session
	task automatic t_supply_low_lockout();
		supply_low_lockout = 1'h1;
		cyc(5);
		chk("int_lockout", 1'h0, int_n);
		supply_low_lockout = 1'h0;
		cyc(DEB+8);
		chk("int_recover", 1'h1, int_n);
		$display("lockout test done");
	endtask : t_supply_low_lockout
	// plain session closed by the host, no fault
	task automatic t_close();
		i_host.open_session();
		chk("close_sup_on", 1'h1, sup_en);
		i_host.close_session(v);
		chk("close_int", 1'h1, v);
		chk("close_sup_off", 1'h0, sup_en);
		chk("close_clk_off", 1'h0, clk_en);
		chk("close_rst_off", 1'h0, rst_en);
		$display("close test done");
	endtask : t_close
	// fault k in session: overload, heat, lockout, removal
	task automatic t_fault(input int k);
		i_host.open_session();
		chk("supply_on", 1'h1, sup_en);
		chk("reset_on", 1'h1, rst_en);
		chk("io_on", 1'h1, io_en);
		chk("aux_on", 1'h1, aux1_en & aux2_en);
		chk("busy_idle", 1'h0, busy);
		ovl = k == 0;
		hot = k == 1;
		supply_low_lockout = k == 2;
		card_presence_input = (k == 3) ? ~pol : pol;
		cyc(5);
		chk("int_fault", 1'h0, int_n);
		chk("reset_off", 1'h0, rst_en);
		chk("clock_held", 1'h1, clk_en);
		chk("io_held", 1'h1, io_en);
		chk("busy_fault", 1'h1, busy);
		cyc(DLY+3);
		chk("supply_off", 1'h0, sup_en);
		chk("io_off", 1'h0, io_en);
		chk("aux_off", 1'h0, aux1_en | aux2_en);
		{ovl, hot, supply_low_lockout, card_presence_input} = {3'h0, pol};
		i_host.close_session(v);
		chk("int_after", 1'h1, v);
		chk("busy_done", 1'h0, busy);
		$display("fault test %0d done", k);
	endtask : t_fault
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#80000;
		err_count++;
		report_and_stop();
	end
	initial begin
		cyc(12);
		rst_in = 1'h0;
		cyc(4);
		t_insert(1'h0);
		t_insert(1'h1);
		t_supply_low_lockout();
		t_close();
		for (int k = 0; k < 4; k++) t_fault(k);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
